// >>> rtl/mcm_pkg.sv
// Constants, register map and timing for the card unit machine-check monitor
package mcm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Wishbone register byte offsets
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_OPER = 8'h04;
    localparam logic [7:0] ADR_LSR11 = 8'h08;
    localparam int unsigned LSR_INDEX = 11;
    // Status bit positions of the check display byte
    localparam int unsigned ST_OVERLAP = 0;
    localparam int unsigned ST_EMIT_NONE = 1;
    localparam int unsigned ST_EMIT_EARLY = 2;
    localparam int unsigned ST_FEED_EXTRA = 3;
    localparam int unsigned ST_FEED_SEQ = 4;
    localparam int unsigned ST_PUSH_EXTRA = 5;
    localparam int unsigned ST_PUNCH_SEQ = 6;
    localparam int unsigned ST_PRINT_SEQ = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Operation register bits
    localparam int unsigned OP_FEED = 0;
    localparam int unsigned OP_READ = 1;
    localparam int unsigned OP_PUNCH = 2;
    localparam int unsigned OP_PRINT = 3;
    localparam int unsigned OP_W = 4;
    localparam logic [3:0] OPER_RESET = 4'h0;
    // Local storage register 11 fields: missing-pulse index plus one (print field 3 for a mistimed interrupt), zero when none
    localparam int unsigned LSR_FEED_LSB = 0;
    localparam int unsigned LSR_PUNCH_LSB = 4;
    localparam int unsigned LSR_PRINT_LSB = 8;
    localparam int unsigned LSR_FIELD_W = 4;
    localparam int unsigned LSR_W = 12;
    localparam logic [11:0] LSR_RESET = 12'h000;
    // Pulse counts per cam sequence
    localparam int unsigned FEED_CAMS = 4;
    localparam int unsigned PUNCH_CAMS = 5;
    localparam int unsigned PRINT_CAMS = 2;
    // Timing
    localparam int unsigned CAM_WINDOW_NS = 20_000_000;
    localparam int unsigned CAM_WINDOW_CYC = CAM_WINDOW_NS / CLK_PERIOD_NS;
    localparam int unsigned PRINT_INT_NS = 50_000;
    localparam int unsigned PRINT_INT_TOL_NS = 5_000;
    localparam int unsigned PRINT_INT_MIN_CYC = (PRINT_INT_NS - PRINT_INT_TOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PRINT_INT_MAX_CYC = (PRINT_INT_NS + PRINT_INT_TOL_NS) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 24;
endpackage

// >>> rtl/mcm_reg_if.sv
// Register access carrier between the monitor core and its bus slave
`timescale 1ns/1ps
interface mcm_reg_if;
    logic [7:0] status;
    logic [mcm_pkg::LSR_W-1:0] local_storage_register;
    logic [mcm_pkg::OP_W-1:0] oper;
    logic op_start;
    modport core (input oper, input op_start, output status, output local_storage_register);
    modport regs (output oper, output op_start, input status, input local_storage_register);
endinterface

// >>> rtl/mcm_cam_seq.sv
// Cam pulse sequence checker: each pulse must follow the previous within a window
`timescale 1ns/1ps
module mcm_cam_seq #(
    parameter int unsigned N = 4,
    parameter int unsigned WIN_CYC = 200000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [N-1:0] pulse_i,
    output logic err_o,
    output logic [mcm_pkg::LSR_FIELD_W-1:0] miss_o
);
    localparam logic [mcm_pkg::CNT_W-1:0] WIN = mcm_pkg::CNT_W'(WIN_CYC);
    logic active;
    logic [mcm_pkg::LSR_FIELD_W-1:0] step;
    logic [mcm_pkg::CNT_W-1:0] cnt;
    logic [N-1:0] expect_mask;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_mask
            assign expect_mask[g] = (step == mcm_pkg::LSR_FIELD_W'(g));
        end
    endgenerate
    wire hit = |(pulse_i & expect_mask);
    wire stray = |(pulse_i & ~expect_mask);
    wire late = (cnt >= WIN);
    wire last = (step == mcm_pkg::LSR_FIELD_W'(N - 1));
    wire fail = active && (stray || (late && !hit));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active <= 1'b0;
            step <= '0;
            cnt <= '0;
            err_o <= 1'b0;
            miss_o <= '0;
        end else begin
            err_o <= fail;
            if (fail) begin
                miss_o <= step + 1'b1;
            end
            if (start_i) begin
                active <= 1'b1;
                step <= '0;
                cnt <= '0;
            end else if (fail || (active && hit && last)) begin
                active <= 1'b0;
            end else if (active && hit) begin
                step <= step + 1'b1;
                cnt <= '0;
            end else if (active) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule // mcm_cam_seq

// >>> rtl/mcm_wb_regs.sv
// Classic Wishbone slave holding the operation register and reading status
`timescale 1ns/1ps
module mcm_wb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    mcm_reg_if.regs rif
);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_oper = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == mcm_pkg::ADR_OPER);
    wire sel_status = (wb_adr_i == mcm_pkg::ADR_STATUS);
    wire sel_oper = (wb_adr_i == mcm_pkg::ADR_OPER);
    wire sel_lsr = (wb_adr_i == mcm_pkg::ADR_LSR11);
    wire [31:0] rd_mux = sel_status ? {24'h00_0000, rif.status} :
                         sel_oper ? {28'h000_0000, rif.oper} :
                         sel_lsr ? {20'h0_0000, rif.local_storage_register} : 32'h0000_0000;
    // Any write that starts an operation clears the latched checks
    assign rif.op_start = wr_oper && (|wb_dat_i[mcm_pkg::OP_W-1:0]);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            rif.oper <= mcm_pkg::OPER_RESET;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_mux;
            end
            if (wr_oper) begin
                rif.oper <= wb_dat_i[mcm_pkg::OP_W-1:0];
            end
        end
    end
endmodule // mcm_wb_regs

// >>> rtl/mcm_monitor.sv
// Top of the card unit machine-check monitor: pulse checks and status latch
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module mcm_monitor #(
    parameter int unsigned CAM_WIN_CYC = mcm_pkg::CAM_WINDOW_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic feed_clutch_pick_i,
    input wire logic [mcm_pkg::FEED_CAMS-1:0] feed_cam_pulse_i,
    input wire logic column_emitter_i,
    input wire logic pusher_clutch_pick_i,
    input wire logic first_cam_timing_pulse_i,
    input wire logic [1:0] punch_cam_pulse_i,
    input wire logic [1:0] incr_cam_pulse_i,
    input wire logic [mcm_pkg::PRINT_CAMS-1:0] print_cam_pulse_i,
    input wire logic print_interrupt_i,
    output logic [7:0] check_display_byte_o,
    output logic [mcm_pkg::LSR_W-1:0] local_storage_register_o,
    output logic machine_check_o
);
    mcm_reg_if rif ();

    mcm_wb_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .rif(rif)
    );

    logic [7:0] status;
    logic [mcm_pkg::LSR_W-1:0] local_storage_register;
    logic feed_picked;
    logic pusher_picked;
    logic feed_cycle;
    logic emitter_seen;
    logic print_run;
    logic [mcm_pkg::CNT_W-1:0] int_cnt;

    wire [mcm_pkg::OP_W-1:0] oper = rif.oper;
    wire read_mode = oper[mcm_pkg::OP_READ];
    wire print_busy = oper[mcm_pkg::OP_PRINT];
    wire first_feed_cam_pulse = feed_cam_pulse_i[0];
    wire second_feed_cam_pulse = feed_cam_pulse_i[1];
    wire print_start = rif.op_start && wb_dat_i[mcm_pkg::OP_PRINT];

    // Sequence checkers for feed, punch/increment and print cams
    wire feed_err;
    wire punch_err;
    wire print_seq_err;
    wire [mcm_pkg::LSR_FIELD_W-1:0] feed_miss;
    wire [mcm_pkg::LSR_FIELD_W-1:0] punch_miss;
    wire [mcm_pkg::LSR_FIELD_W-1:0] print_miss;
    wire [mcm_pkg::PUNCH_CAMS-1:0] punch_pulses = {incr_cam_pulse_i, punch_cam_pulse_i, first_cam_timing_pulse_i};

    mcm_cam_seq #(
        .N(mcm_pkg::FEED_CAMS),
        .WIN_CYC(CAM_WIN_CYC)
    ) u_feed_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(feed_clutch_pick_i),
        .pulse_i(feed_cam_pulse_i),
        .err_o(feed_err),
        .miss_o(feed_miss)
    );

    mcm_cam_seq #(
        .N(mcm_pkg::PUNCH_CAMS),
        .WIN_CYC(CAM_WIN_CYC)
    ) u_punch_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(pusher_clutch_pick_i),
        .pulse_i(punch_pulses),
        .err_o(punch_err),
        .miss_o(punch_miss)
    );

    mcm_cam_seq #(
        .N(mcm_pkg::PRINT_CAMS),
        .WIN_CYC(CAM_WIN_CYC)
    ) u_print_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(print_start),
        .pulse_i(print_cam_pulse_i),
        .err_o(print_seq_err),
        .miss_o(print_miss)
    );

    // Periodic print interrupt: too early or too late both count as mistimed
    localparam logic [mcm_pkg::CNT_W-1:0] INT_MIN = mcm_pkg::CNT_W'(mcm_pkg::PRINT_INT_MIN_CYC);
    localparam logic [mcm_pkg::CNT_W-1:0] INT_MAX = mcm_pkg::CNT_W'(mcm_pkg::PRINT_INT_MAX_CYC);
    localparam logic [mcm_pkg::LSR_FIELD_W-1:0] INT_MISS_CODE = mcm_pkg::LSR_FIELD_W'(mcm_pkg::PRINT_CAMS + 1);
    wire int_early = print_run && print_interrupt_i && (int_cnt < INT_MIN);
    wire int_late = print_run && !print_interrupt_i && (int_cnt >= INT_MAX);
    wire int_err = int_early || int_late;

    // Event terms feeding the status byte
    wire ev_overlap = oper[mcm_pkg::OP_PUNCH] && print_busy;
    wire ev_emit_none = read_mode && second_feed_cam_pulse && !emitter_seen && !column_emitter_i;
    wire ev_emit_early = feed_cycle && column_emitter_i && !first_feed_cam_pulse;
    wire ev_feed_extra = first_feed_cam_pulse && !feed_picked && !feed_clutch_pick_i;
    wire ev_push_extra = first_cam_timing_pulse_i && !pusher_picked && !pusher_clutch_pick_i;
    wire ev_print = print_seq_err || int_err;

    wire [7:0] events;
    assign events[mcm_pkg::ST_OVERLAP] = ev_overlap;
    assign events[mcm_pkg::ST_EMIT_NONE] = ev_emit_none;
    assign events[mcm_pkg::ST_EMIT_EARLY] = ev_emit_early;
    assign events[mcm_pkg::ST_FEED_EXTRA] = ev_feed_extra;
    assign events[mcm_pkg::ST_FEED_SEQ] = feed_err;
    assign events[mcm_pkg::ST_PUSH_EXTRA] = ev_push_extra;
    assign events[mcm_pkg::ST_PUNCH_SEQ] = punch_err;
    assign events[mcm_pkg::ST_PRINT_SEQ] = ev_print;

    // Latched byte: an operation start clears, but a same-cycle event still sets
    wire [7:0] status_base = rif.op_start ? mcm_pkg::STATUS_RESET : status;
    wire [7:0] next_status = status_base | events;

    // Missing-pulse record for the three sequence checks
    wire [mcm_pkg::LSR_W-1:0] lsr_base = rif.op_start ? mcm_pkg::LSR_RESET : local_storage_register;
    wire [mcm_pkg::LSR_FIELD_W-1:0] print_code = print_seq_err ? print_miss : INT_MISS_CODE;
    wire [mcm_pkg::LSR_W-1:0] next_lsr = {
        ev_print ? print_code : lsr_base[mcm_pkg::LSR_PRINT_LSB +: mcm_pkg::LSR_FIELD_W],
        punch_err ? punch_miss : lsr_base[mcm_pkg::LSR_PUNCH_LSB +: mcm_pkg::LSR_FIELD_W],
        feed_err ? feed_miss : lsr_base[mcm_pkg::LSR_FEED_LSB +: mcm_pkg::LSR_FIELD_W]
    };

    assign rif.status = status;
    assign rif.local_storage_register = local_storage_register;
    assign check_display_byte_o = status;
    assign local_storage_register_o = local_storage_register;
    assign machine_check_o = |status[7:1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= mcm_pkg::STATUS_RESET;
            local_storage_register <= mcm_pkg::LSR_RESET;
        end else begin
            status <= next_status;
            local_storage_register <= next_lsr;
        end
    end

    // Clutch pick memory: a pick arms the matching first cam pulse once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feed_picked <= 1'b0;
            pusher_picked <= 1'b0;
        end else begin
            feed_picked <= feed_clutch_pick_i || (feed_picked && !first_feed_cam_pulse);
            pusher_picked <= pusher_clutch_pick_i || (pusher_picked && !first_cam_timing_pulse_i);
        end
    end

    // Feed cycle window and column emitter tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feed_cycle <= 1'b0;
            emitter_seen <= 1'b0;
        end else begin
            feed_cycle <= feed_clutch_pick_i || (feed_cycle && !first_feed_cam_pulse);
            if (feed_clutch_pick_i || second_feed_cam_pulse) begin
                emitter_seen <= 1'b0;
            end else if (column_emitter_i) begin
                emitter_seen <= 1'b1;
            end
        end
    end

    // Print interrupt interval counter, live while the print operation runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            print_run <= 1'b0;
            int_cnt <= '0;
        end else begin
            print_run <= print_busy && !int_err;
            if (!print_busy || print_interrupt_i || int_err) begin
                int_cnt <= '0;
            end else begin
                int_cnt <= int_cnt + 1'b1;
            end
        end
    end
endmodule // mcm_monitor

// >>> testbench/mcm_monitor_sva.sv
// Port-level assertion checker for the machine-check monitor
`timescale 1ns/1ps
module mcm_monitor_sva #(
    parameter int unsigned CAM_WIN_CYC = mcm_pkg::CAM_WINDOW_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic feed_clutch_pick_i,
    input wire logic [mcm_pkg::FEED_CAMS-1:0] feed_cam_pulse_i,
    input wire logic column_emitter_i,
    input wire logic pusher_clutch_pick_i,
    input wire logic first_cam_timing_pulse_i,
    input wire logic [1:0] punch_cam_pulse_i,
    input wire logic [1:0] incr_cam_pulse_i,
    input wire logic [mcm_pkg::PRINT_CAMS-1:0] print_cam_pulse_i,
    input wire logic print_interrupt_i,
    input wire logic [7:0] check_display_byte_o,
    input wire logic [mcm_pkg::LSR_W-1:0] local_storage_register_o,
    input wire logic machine_check_o
);
    logic [3:0] oper;
    logic feed_pend;
    logic push_pend;
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire oper_wr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == mcm_pkg::ADR_OPER);
    wire start = oper_wr & (wb_dat_i[3:0] != 4'h0);
    // Shadow of the operation register and of clutch picks still awaiting their first cam
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oper <= 4'h0;
            feed_pend <= 1'b0;
            push_pend <= 1'b0;
        end else begin
            oper <= oper_wr ? wb_dat_i[3:0] : oper;
            feed_pend <= feed_clutch_pick_i | (feed_pend & ~feed_cam_pulse_i[0]);
            push_pend <= pusher_clutch_pick_i | (push_pend & ~first_cam_timing_pulse_i);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_take(logic [7:0] adr);
        take && !wb_we_i && wb_adr_i == adr;
    endsequence
    a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_mc_summary: assert property (machine_check_o == |check_display_byte_o[7:1])
        else $error("summary does not match status bits 7..1");
    a_bits_latched: assert property (!start |=> (check_display_byte_o & $past(check_display_byte_o)) ==
        $past(check_display_byte_o)) else $error("status bit dropped without start");
    a_overlap_set: assert property (oper[2] && oper[3] |=> check_display_byte_o[0])
        else $error("overlap bit not set");
    a_extra_feed: assert property (feed_cam_pulse_i[0] && !feed_pend && !feed_clutch_pick_i |=>
        check_display_byte_o[3]) else $error("extra feed cycle not flagged");
    a_extra_push: assert property (first_cam_timing_pulse_i && !push_pend && !pusher_clutch_pick_i |=>
        check_display_byte_o[5]) else $error("extra pusher cycle not flagged");
    a_emit_early: assert property (column_emitter_i && feed_pend && !feed_cam_pulse_i[0] |=>
        check_display_byte_o[2]) else $error("early emitter not flagged");
    a_unmapped_zero: assert property (rd_take(8'h0C) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_read: assert property (rd_take(mcm_pkg::ADR_STATUS) |=> wb_dat_o == {24'h00_0000,
        $past(check_display_byte_o)}) else $error("status read mismatch");
endmodule // mcm_monitor_sva

// >>> testbench/mcm_mech_model.sv
// Card mechanism model: clutch picks, cam pulses, emitter and print interrupt
`timescale 1ns/1ps
module mcm_mech_model (
    input wire logic clk_i,
    output logic [14:0] pins_o
);
    initial pins_o = 15'h0000;
    task pulse(input int idx, input int gap);
        @(posedge clk_i);
        pins_o[idx] <= 1'b1;
        @(posedge clk_i);
        pins_o[idx] <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask
    // A cam train; the dropped pulse leaves a gap longer than the window
    task run(input int base, input int n, input int drop);
        for (int i = 0; i < n; i++) begin
            if (i == drop) repeat (30) @(posedge clk_i);
            else pulse(base + i, 3);
        end
    endtask
    task ticks(input int n);
        repeat (n) begin
            repeat (497) @(posedge clk_i);
            pulse(14, 0);
        end
    endtask
endmodule // mcm_mech_model

// >>> testbench/mcm_monitor_tb.sv
// Self-checking testbench for the machine-check monitor
`timescale 1ns/1ps
module mcm_monitor_tb;
    localparam logic [7:0] OP = mcm_pkg::ADR_OPER;
    localparam logic [7:0] LS = mcm_pkg::ADR_LSR11;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [14:0] pins;
    logic [7:0] cdb;
    logic [11:0] lsr_pins;
    logic mc;
    logic [31:0] rd;
    int bad_count = 0;
    int n_compared = 0;
    always #50 clk_i = ~clk_i;
    mcm_mech_model mech (.clk_i(clk_i), .pins_o(pins));
    mcm_monitor #(.CAM_WIN_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .feed_clutch_pick_i(pins[0]), .feed_cam_pulse_i(pins[4:1]), .column_emitter_i(pins[5]),
        .pusher_clutch_pick_i(pins[6]), .first_cam_timing_pulse_i(pins[7]), .punch_cam_pulse_i(pins[9:8]),
        .incr_cam_pulse_i(pins[11:10]), .print_cam_pulse_i(pins[13:12]), .print_interrupt_i(pins[14]),
        .check_display_byte_o(cdb), .local_storage_register_o(lsr_pins), .machine_check_o(mc));
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        wb(adr, 1'b0, 32'h0000_0000);
        chk($sformatf("register %h", adr), exp, rd & mask);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("[ERR] watchdog expected done seen timeout");
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rchk(LS, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(8'h0C, 1'b1, 32'h0000_00FF);
        rchk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(OP, 1'b1, 32'h0000_0003);
        mech.pulse(0, 3);
        mech.run(1, 4, 9);
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
        chk("machine check", 32'h0000_0001, {31'h0, mc});
        repeat (50) @(posedge clk_i);
        wb(OP, 1'b1, 32'h0000_0000);
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
        wb(OP, 1'b1, 32'h0000_0003);
        mech.pulse(0, 3);
        mech.run(1, 1, 9);
        mech.pulse(5, 3);
        mech.run(2, 3, 9);
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(OP, 1'b1, 32'h0000_0001);
        mech.pulse(0, 3);
        mech.pulse(5, 3);
        mech.run(1, 4, 9);
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0004);
        wb(OP, 1'b1, 32'h0000_0001);
        mech.run(1, 4, 9);
        rchk(mcm_pkg::ADR_STATUS, 32'h0000_0008, 32'h0000_0008);
        for (int d = 0; d < 4; d++) begin
            wb(OP, 1'b1, 32'h0000_0001);
            mech.pulse(0, 3);
            mech.run(1, 4, d);
            rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0010);
            rchk(LS, 32'hFFFF_FFFF, d + 1);
        end
        wb(OP, 1'b1, 32'h0000_0004);
        mech.run(7, 1, 9);
        rchk(mcm_pkg::ADR_STATUS, 32'h0000_0020, 32'h0000_0020);
        for (int d = 0; d < 5; d++) begin
            wb(OP, 1'b1, 32'h0000_0004);
            mech.pulse(6, 3);
            mech.run(7, 5, d);
            rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0040);
            rchk(LS, 32'hFFFF_FFFF, (d + 1) * 16);
        end
        for (int d = 0; d < 2; d++) begin
            wb(OP, 1'b1, 32'h0000_0008);
            mech.run(12, 2, d);
            rchk(mcm_pkg::ADR_STATUS, 32'h0000_0080, 32'h0000_0080);
            rchk(LS, 32'h0000_0F00, (d + 1) * 256);
        end
        // Drop print busy so the interrupt interval restarts with this operation
        wb(OP, 1'b1, 32'h0000_0000);
        wb(OP, 1'b1, 32'h0000_0008);
        mech.run(12, 2, 9);
        mech.ticks(2);
        rchk(mcm_pkg::ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        repeat (600) @(posedge clk_i);
        rchk(mcm_pkg::ADR_STATUS, 32'h0000_0080, 32'h0000_0080);
        rchk(LS, 32'h0000_0F00, 32'h0000_0300);
        chk("missing pulse pins", 32'h0000_0300, {20'h0_0000, lsr_pins});
        wb(OP, 1'b1, 32'h0000_000C);
        repeat (2) @(posedge clk_i);
        chk("overlap byte and summary", 32'h0000_0002, {23'h0, cdb, mc});
        rchk(OP, 32'hFFFF_FFFF, 32'h0000_000C);
        wb(OP, 1'b1, 32'h0000_0000);
        stop_test();
    end
endmodule // mcm_monitor_tb
bind mcm_monitor mcm_monitor_sva #(.CAM_WIN_CYC(CAM_WIN_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .feed_clutch_pick_i(feed_clutch_pick_i),
    .feed_cam_pulse_i(feed_cam_pulse_i), .column_emitter_i(column_emitter_i),
    .pusher_clutch_pick_i(pusher_clutch_pick_i), .first_cam_timing_pulse_i(first_cam_timing_pulse_i),
    .punch_cam_pulse_i(punch_cam_pulse_i), .incr_cam_pulse_i(incr_cam_pulse_i),
    .print_cam_pulse_i(print_cam_pulse_i), .print_interrupt_i(print_interrupt_i),
    .check_display_byte_o(check_display_byte_o), .local_storage_register_o(local_storage_register_o),
    .machine_check_o(machine_check_o));
